// ===== rtl/pbl_dev.sv
`timescale 1ns/1ps
module pbl_dev
  import pbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pbl_if.dev link,
  output logic store_we,
  output logic [7:0] store_num,
  output logic [31:0] store_data,
  output logic req_done,
  output logic [15:0] req_code,
  output logic stat_is_bits,
  output logic [15:0] stat_loc,
  output logic [15:0] stat_span,
  output logic data_is_bits,
  output logic [15:0] data_loc,
  output logic [15:0] data_span
);
  typedef enum logic [1:0] {
    D_RECV = 2'b00,
    D_CHECK = 2'b01,
    D_COMMIT = 2'b11,
    D_REPLY = 2'b10
  } pbl_dst_t;

  pbl_dst_t state_reg, state_next;
  logic [5:0] idx_reg, idx_next;
  logic [15:0] hdr_reg, hdr_next;
  logic [15:0] stype_reg, stype_next;
  logic [15:0] soff_reg, soff_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [15:0] bytes_reg, bytes_next;
  logic [15:0] dtype_reg, dtype_next;
  logic [15:0] doff_reg, doff_next;
  logic [15:0] start_reg, start_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] stage_reg [0:31];
  logic [15:0] stage_next [0:31];
  logic [4:0] k_reg, k_next;
  logic [15:0] code_reg, code_next;
  logic store_we_reg, store_we_next;
  logic [7:0] store_num_reg, store_num_next;
  logic [31:0] store_data_reg, store_data_next;
  logic [15:0] chk_code;
  logic [4:0] slot;
  logic stat_is_bits_reg, stat_is_bits_next;
  logic [15:0] stat_loc_reg, stat_loc_next;
  logic [15:0] stat_span_reg, stat_span_next;
  logic data_is_bits_reg, data_is_bits_next;
  logic [15:0] data_loc_reg, data_loc_next;
  logic [15:0] data_span_reg, data_span_next;

  pbl_blk_check u_check (
    .hdr_len(hdr_reg),
    .cmd(cmd_reg),
    .bytes(bytes_reg),
    .stype(stype_reg),
    .dtype(dtype_reg),
    .start(start_reg),
    .count(count_reg),
    .nwords(idx_reg),
    .code(chk_code)
  );

  // ----------------------------------------------------------------
  // link handshake and user outputs
  // ----------------------------------------------------------------
  assign link.word_ready = (state_reg == D_RECV);
  assign link.result_valid = (state_reg == D_REPLY);
  assign link.result_code = code_reg;
  assign req_done = (state_reg == D_REPLY);
  assign req_code = code_reg;
  assign store_we = store_we_reg;
  assign store_num = store_num_reg;
  assign store_data = store_data_reg;

  // decoded placement of status word and data
  always_comb begin
    stat_is_bits_next = area_is_bit(stype_reg);
    stat_loc_next = soff_reg + 16'h0001;
    stat_span_next = stat_is_bits_next ? STAT_BITS : 16'h0001;
    data_is_bits_next = area_is_bit(dtype_reg);
    data_loc_next = doff_reg + 16'h0001;
    if (data_is_bits_next) begin
      data_span_next = (CNTW_BITS << 1) + PARAM_BITS * count_reg;
    end else begin
      data_span_next = 16'h0002 + (count_reg << 1);
    end
  end

  // placement registers, outputs straight from flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_is_bits_reg <= 1'b0;
      stat_loc_reg <= 16'h0000;
      stat_span_reg <= 16'h0000;
      data_is_bits_reg <= 1'b0;
      data_loc_reg <= 16'h0000;
      data_span_reg <= 16'h0000;
    end else begin
      stat_is_bits_reg <= stat_is_bits_next;
      stat_loc_reg <= stat_loc_next;
      stat_span_reg <= stat_span_next;
      data_is_bits_reg <= data_is_bits_next;
      data_loc_reg <= data_loc_next;
      data_span_reg <= data_span_next;
    end
  end

  // placement outputs
  assign stat_is_bits = stat_is_bits_reg;
  assign stat_loc = stat_loc_reg;
  assign stat_span = stat_span_reg;
  assign data_is_bits = data_is_bits_reg;
  assign data_loc = data_loc_reg;
  assign data_span = data_span_reg;

  // ----------------------------------------------------------------
  // receive, check, commit, reply
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    hdr_next = hdr_reg;
    stype_next = stype_reg;
    soff_next = soff_reg;
    cmd_next = cmd_reg;
    bytes_next = bytes_reg;
    dtype_next = dtype_reg;
    doff_next = doff_reg;
    start_next = start_reg;
    count_next = count_reg;
    stage_next = stage_reg;
    k_next = k_reg;
    code_next = code_reg;
    store_we_next = 1'b0;
    store_num_next = store_num_reg;
    store_data_next = store_data_reg;
    slot = 5'(idx_reg - 6'(W_DATA));
    unique case (state_reg)
      D_RECV: begin
        if (link.word_valid) begin
          // words beyond the largest block are dropped but counted; the count holds at 63
          case (int'(idx_reg))
            W_HDR: hdr_next = link.word_data;
            W_STYPE: stype_next = link.word_data;
            W_SOFF: soff_next = link.word_data;
            W_CMD: cmd_next = link.word_data;
            W_BYTES: bytes_next = link.word_data;
            W_DTYPE: dtype_next = link.word_data;
            W_DOFF: doff_next = link.word_data;
            W_START: start_next = link.word_data;
            W_COUNT: count_next = link.word_data;
            default: begin
              // mode and timeout words are not kept
              if (int'(idx_reg) >= W_DATA && int'(idx_reg) < BLK_WORDS_MAX) begin
                stage_next[slot] = link.word_data;
              end
            end
          endcase
          if (idx_reg != 6'h3f) begin
            idx_next = idx_reg + 6'h01;
          end
          if (link.word_last) begin
            state_next = D_CHECK;
          end
        end
      end
      D_CHECK: begin
        code_next = chk_code;
        k_next = 5'h00;
        state_next = (chk_code == ST_OK) ? D_COMMIT : D_REPLY;
      end
      D_COMMIT: begin
        store_we_next = 1'b1;
        store_num_next = 8'(start_reg + {11'h000, k_reg});
        store_data_next = {stage_reg[{k_reg[3:0], 1'b1}],
                           stage_reg[{k_reg[3:0], 1'b0}]};
        k_next = k_reg + 5'h01;
        if ({11'h000, k_reg} == count_reg - 16'h0001) begin
          state_next = D_REPLY;
        end
      end
      D_REPLY: begin
        idx_next = 6'h00;
        state_next = D_RECV;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= D_RECV;
      idx_reg <= 6'h00;
      hdr_reg <= 16'h0000;
      stype_reg <= 16'h0000;
      soff_reg <= 16'h0000;
      cmd_reg <= 16'h0000;
      bytes_reg <= 16'h0000;
      dtype_reg <= 16'h0000;
      doff_reg <= 16'h0000;
      start_reg <= 16'h0000;
      count_reg <= 16'h0000;
      for (int i = 0; i < 32; i++) begin
        stage_reg[i] <= 16'h0000;
      end
      k_reg <= 5'h00;
      code_reg <= 16'h0000;
      store_we_reg <= 1'b0;
      store_num_reg <= 8'h00;
      store_data_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      hdr_reg <= hdr_next;
      stype_reg <= stype_next;
      soff_reg <= soff_next;
      cmd_reg <= cmd_next;
      bytes_reg <= bytes_next;
      dtype_reg <= dtype_next;
      doff_reg <= doff_next;
      start_reg <= start_next;
      count_reg <= count_next;
      stage_reg <= stage_next;
      k_reg <= k_next;
      code_reg <= code_next;
      store_we_reg <= store_we_next;
      store_num_reg <= store_num_next;
      store_data_reg <= store_data_next;
    end
  end
endmodule

// ===== rtl/pbl_pkg.sv
package pbl_pkg;

  // ----------------------------------------------------------------
  // command block layout (zero-based word index from block start)
  // ----------------------------------------------------------------
  localparam int W_HDR = 0;
  localparam int W_MODE = 1;
  localparam int W_STYPE = 2;
  localparam int W_SOFF = 3;
  localparam int W_IDLE = 4;
  localparam int W_MAXT = 5;
  localparam int W_CMD = 6;
  localparam int W_BYTES = 7;
  localparam int W_DTYPE = 8;
  localparam int W_DOFF = 9;
  localparam int W_START = 10;
  localparam int W_COUNT = 11;
  localparam int W_DATA = 12;
  localparam int BLK_WORDS_MAX = 44;
  localparam int HDR_WORDS_SENT = 10;

  // ----------------------------------------------------------------
  // fixed values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] HDR_LEN_VAL = 16'h0004;
  localparam logic [15:0] CMD_LOAD = 16'he501;
  localparam logic [15:0] MT_REG = 16'h0008;
  localparam logic [15:0] MT_AIN = 16'h000a;
  localparam logic [15:0] MT_AOUT = 16'h000c;
  localparam logic [15:0] MT_DIN = 16'h0046;
  localparam logic [15:0] MT_DOUT = 16'h0048;
  localparam logic [15:0] BYTES_BASE = 16'h0004;
  localparam logic [15:0] BYTES_MAX = 16'h0044;
  localparam logic [15:0] CNT_MIN = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'h0010;
  localparam logic [16:0] PNUM_MAX = 17'h000ff;
  localparam logic [15:0] STAT_BITS = 16'h0010;
  localparam logic [15:0] PARAM_BITS = 16'h0020;
  localparam logic [15:0] CNTW_BITS = 16'h0010;

  // ----------------------------------------------------------------
  // status word values
  // ----------------------------------------------------------------
  localparam logic [15:0] ST_OK = 16'h0001;
  localparam logic [15:0] ST_BAD_HDR = 16'h0002;
  localparam logic [15:0] ST_BAD_CMD = 16'h0003;
  localparam logic [15:0] ST_BAD_TYPE = 16'h0004;
  localparam logic [15:0] ST_BAD_CNT = 16'h0005;
  localparam logic [15:0] ST_BAD_SIZE = 16'h0006;
  localparam logic [15:0] ST_BAD_RANGE = 16'h0007;
  localparam logic [15:0] ST_BAD_LEN = 16'h0008;

  // ----------------------------------------------------------------
  // host controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_STAT = 10'h004;
  localparam logic [9:0] REG_BLKPTR = 10'h008;
  localparam logic [9:0] REG_RESULT = 10'h00c;
  localparam logic [9:0] MEM_BASE = 10'h200;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_DONE_BIT = 2;

  // area code decode helpers
  function automatic logic area_is_word(input logic [15:0] code);
    return (code == MT_REG) || (code == MT_AIN) || (code == MT_AOUT);
  endfunction

  function automatic logic area_is_bit(input logic [15:0] code);
    return (code == MT_DIN) || (code == MT_DOUT);
  endfunction

endpackage

// ===== rtl/pbl_if.sv
`timescale 1ns/1ps
interface pbl_if;
  logic word_valid;
  logic word_ready;
  logic word_last;
  logic [15:0] word_data;
  logic result_valid;
  logic [15:0] result_code;

  modport dev (
    input word_valid,
    input word_last,
    input word_data,
    output word_ready,
    output result_valid,
    output result_code
  );

  modport host (
    output word_valid,
    output word_last,
    output word_data,
    input word_ready,
    input result_valid,
    input result_code
  );
endinterface

// ===== rtl/pbl_blk_check.sv
`timescale 1ns/1ps
module pbl_blk_check
  import pbl_pkg::*;
(
  input wire logic [15:0] hdr_len,
  input wire logic [15:0] cmd,
  input wire logic [15:0] bytes,
  input wire logic [15:0] stype,
  input wire logic [15:0] dtype,
  input wire logic [15:0] start,
  input wire logic [15:0] count,
  input wire logic [5:0] nwords,
  output logic [15:0] code
);
  logic [16:0] last_num;
  logic [15:0] want_bytes;
  logic [15:0] want_words;

  // ----------------------------------------------------------------
  // validation in fixed priority order
  // ----------------------------------------------------------------
  always_comb begin
    last_num = {1'b0, start} + {1'b0, count} - 17'h00001;
    want_bytes = BYTES_BASE + (count << 2);
    want_words = 16'(W_DATA) + (count << 1);
    if (hdr_len != HDR_LEN_VAL) begin
      code = ST_BAD_HDR;
    end else if (cmd != CMD_LOAD) begin
      code = ST_BAD_CMD;
    end else if (!(area_is_word(stype) || area_is_bit(stype)) ||
                 !(area_is_word(dtype) || area_is_bit(dtype))) begin
      code = ST_BAD_TYPE;
    end else if (count < CNT_MIN || count > CNT_MAX) begin
      code = ST_BAD_CNT;
    end else if (bytes != want_bytes || bytes > BYTES_MAX) begin
      code = ST_BAD_SIZE;
    end else if ({1'b0, start} > PNUM_MAX || last_num > PNUM_MAX) begin
      code = ST_BAD_RANGE;
    end else if ({10'h000, nwords} != want_words) begin
      code = ST_BAD_LEN;
    end else begin
      code = ST_OK;
    end
  end
endmodule

// ===== rtl/pbl_host.sv
`timescale 1ns/1ps
module pbl_host
  import pbl_pkg::*;
#(
  parameter int MEM_WORDS = 64
)
(
  input wire logic clk,
  input wire logic rst,
  pbl_if.host link,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic request_fault_output
);
  localparam int AW = $clog2(MEM_WORDS);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CHECK = 3'b001,
    H_SEND = 3'b011,
    H_WAIT = 3'b010,
    H_STAT = 3'b110
  } pbl_hst_t;

  pbl_hst_t state_reg, state_next;
  logic [15:0] mem_reg [0:MEM_WORDS-1];
  logic [15:0] mem_next [0:MEM_WORDS-1];
  logic [AW-1:0] ptr_reg, ptr_next;
  logic [5:0] i_reg, i_next;
  logic [5:0] total_reg, total_next;
  logic [15:0] res_reg, res_next;
  logic fault_reg, fault_next;
  logic done_reg, done_next;
  logic [15:0] wdata_reg, wdata_next;
  logic wlast_reg, wlast_next;
  logic rd_pend_reg, rd_pend_next;
  logic [31:0] rdata_reg, rdata_next;
  logic mem_sel;
  logic [AW-1:0] mem_idx;
  logic [15:0] bytes;
  logic [15:0] capped;
  logic bus_wr;

  // word of the block at position n, mode and timeout forced to zero
  function automatic logic [15:0] blk_word(input logic [5:0] n);
    logic [AW-1:0] a;
    a = AW'(ptr_reg + AW'(n));
    if (int'(n) == W_MODE || int'(n) == W_IDLE || int'(n) == W_MAXT) begin
      return 16'h0000;
    end
    return mem_reg[a];
  endfunction

  // ----------------------------------------------------------------
  // avalon slave decode
  // ----------------------------------------------------------------
  assign mem_sel = (address >= MEM_BASE) &&
                   (address < MEM_BASE + 10'(MEM_WORDS * 4));
  assign mem_idx = AW'((address - MEM_BASE) >> 2);
  // reads take one wait state; memory writes stall while status lands
  assign waitrequest = (read && !rd_pend_reg) ||
                       (write && mem_sel && state_reg == H_STAT);
  assign bus_wr = write && !waitrequest;
  assign readdata = rdata_reg;
  assign request_fault_output = fault_reg;
  assign link.word_valid = (state_reg == H_SEND);
  assign link.word_data = wdata_reg;
  assign link.word_last = wlast_reg;

  // ----------------------------------------------------------------
  // request sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mem_next = mem_reg;
    ptr_next = ptr_reg;
    i_next = i_reg;
    total_next = total_reg;
    res_next = res_reg;
    fault_next = fault_reg;
    done_next = done_reg;
    wdata_next = wdata_reg;
    wlast_next = wlast_reg;
    rd_pend_next = 1'b0;
    rdata_next = rdata_reg;
    bytes = mem_reg[AW'(ptr_reg + AW'(W_BYTES))];
    capped = (bytes > BYTES_MAX) ? BYTES_MAX : bytes;
    if (read && !rd_pend_reg) begin
      rd_pend_next = 1'b1;
      if (mem_sel) begin
        rdata_next = {16'h0000, mem_reg[mem_idx]};
      end else if (address == REG_STAT) begin
        rdata_next = {29'h0, done_reg, fault_reg, state_reg != H_IDLE};
      end else if (address == REG_BLKPTR) begin
        rdata_next = 32'(ptr_reg);
      end else if (address == REG_RESULT) begin
        rdata_next = {16'h0000, res_reg};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
    if (bus_wr && mem_sel) begin
      mem_next[mem_idx] = writedata[15:0];
    end
    if (bus_wr && address == REG_BLKPTR && state_reg == H_IDLE) begin
      ptr_next = writedata[AW-1:0];
    end
    unique case (state_reg)
      H_IDLE: begin
        if (bus_wr && address == REG_CTRL && writedata[CTRL_GO_BIT]) begin
          fault_next = 1'b0;
          done_next = 1'b0;
          state_next = H_CHECK;
        end
      end
      H_CHECK: begin
        if (bytes == 16'h0000) begin
          fault_next = 1'b1;
          done_next = 1'b1;
          state_next = H_IDLE;
        end else begin
          total_next = 6'(HDR_WORDS_SENT) + 6'(capped >> 1);
          i_next = 6'h00;
          wdata_next = blk_word(6'h00);
          wlast_next = 1'b0;
          state_next = H_SEND;
        end
      end
      H_SEND: begin
        if (link.word_ready) begin
          i_next = i_reg + 6'h01;
          wdata_next = blk_word(i_reg + 6'h01);
          wlast_next = (i_reg + 6'h02 == total_reg);
          if (wlast_reg) begin
            state_next = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        if (link.result_valid) begin
          res_next = link.result_code;
          state_next = H_STAT;
        end
      end
      H_STAT: begin
        mem_next[AW'(mem_reg[AW'(ptr_reg + AW'(W_SOFF))])] = res_reg;
        done_next = 1'b1;
        state_next = H_IDLE;
      end
      default: state_next = H_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= H_IDLE;
      for (int k = 0; k < MEM_WORDS; k++) begin
        mem_reg[k] <= 16'h0000;
      end
      ptr_reg <= '0;
      i_reg <= 6'h00;
      total_reg <= 6'h00;
      res_reg <= 16'h0000;
      fault_reg <= 1'b0;
      done_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      wlast_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      mem_reg <= mem_next;
      ptr_reg <= ptr_next;
      i_reg <= i_next;
      total_reg <= total_next;
      res_reg <= res_next;
      fault_reg <= fault_next;
      done_reg <= done_next;
      wdata_reg <= wdata_next;
      wlast_reg <= wlast_next;
      rd_pend_reg <= rd_pend_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

// ===== tb/pbl_chk.sv
`timescale 1ns/1ps
module pbl_chk
  import pbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic word_last,
  input wire logic [15:0] word_data,
  input wire logic result_valid,
  input wire logic [15:0] result_code
);
  logic [15:0] w_reg [12];
  logic [5:0] idx_reg;
  logic [15:0] n;
  logic [15:0] cap;
  logic b_hdr;
  logic b_cmd;
  logic b_area;
  logic b_cnt;
  logic b_size;
  logic b_rng;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // header copy of the block on the wire
  // ----------------------------------------
  assign n = w_reg[11];
  assign cap = (w_reg[7] > BYTES_MAX) ? BYTES_MAX : w_reg[7];
  assign b_hdr = w_reg[0] != HDR_LEN_VAL;
  assign b_cmd = w_reg[6] != CMD_LOAD;
  assign b_area = !(w_reg[2] inside {MT_REG, MT_AIN, MT_AOUT, MT_DIN, MT_DOUT}) ||
    !(w_reg[8] inside {MT_REG, MT_AIN, MT_AOUT, MT_DIN, MT_DOUT});
  assign b_cnt = (n < CNT_MIN) || (n > CNT_MAX);
  assign b_size = w_reg[7] != BYTES_BASE + (n << 2);
  assign b_rng = ({1'b0, w_reg[10]} + {1'b0, n}) > (PNUM_MAX + 17'h00001);
  // word index, stale words poisoned at block start
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_reg <= 6'h00;
    end else if (word_valid && word_ready) begin
      idx_reg <= word_last ? 6'h00 : idx_reg + 6'h01;
      for (int k = 0; k < 12; k++) begin
        if (idx_reg == 6'(k)) begin
          w_reg[k] <= word_data;
        end else if (idx_reg == 6'h00) begin
          w_reg[k] <= 16'hffff;
        end
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_last;
    word_valid && word_ready && word_last;
  endsequence
  sequence s_answer;
    ##[1:20] result_valid;
  endsequence
  AST_ANSWER: assert property (s_last |-> s_answer)
    else $error("no result after block");
  AST_HOLD_OFF: assert property (s_last |=> !word_ready until result_valid)
    else $error("ready before result");
  AST_PULSE: assert property (result_valid |=> !result_valid)
    else $error("result longer than one cycle");
  AST_HDR: assert property (result_valid && b_hdr |-> result_code != ST_OK)
    else $error("bad header length accepted");
  AST_CMD: assert property (result_valid && b_cmd |-> result_code != ST_OK)
    else $error("bad command accepted");
  AST_AREA: assert property (result_valid && b_area |-> result_code != ST_OK)
    else $error("bad area code accepted");
  AST_COUNT: assert property (result_valid && b_cnt |-> result_code != ST_OK)
    else $error("bad count accepted");
  AST_SIZE: assert property (result_valid && b_size |-> result_code != ST_OK)
    else $error("bad byte size accepted");
  AST_RANGE: assert property (result_valid && b_rng |-> result_code != ST_OK)
    else $error("bad range accepted");
  AST_OK: assert property (result_valid && !(b_hdr || b_cmd || b_area || b_cnt || b_size ||
    b_rng) |-> result_code == ST_OK)
    else $error("good block refused");
  AST_ZERO: assert property (word_valid && word_ready && (idx_reg inside {6'h01, 6'h04, 6'h05})
    |-> word_data == 16'h0000)
    else $error("mode or timeout word not zero");
  AST_SENT: assert property (s_last |-> ({10'h000, idx_reg} + 16'h0001) ==
    (16'h000a + (cap >> 1)))
    else $error("wrong number of words sent");
endmodule

// ===== tb/tb_param_block_loader.sv
`timescale 1ns/1ps
module tb_param_block_loader;
  import pbl_pkg::*;
  logic clk;
  logic rst;
  logic [9:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic request_fault_output;
  logic store_we;
  logic [7:0] store_num;
  logic [31:0] store_data;
  logic req_done;
  logic [15:0] req_code;
  logic stat_is_bits;
  logic [15:0] stat_loc;
  logic [15:0] stat_span;
  logic data_is_bits;
  logic [15:0] data_loc;
  logic [15:0] data_span;
  int fails;
  int n_compared;
  int cyc;
  int seed;
  logic [15:0] blk [44];
  logic [39:0] got_q [$];
  logic [15:0] code_q [$];
  logic [15:0] codes [5];
  pbl_if lnk();
  // ----------------------------------------
  // both ends and the checker
  // ----------------------------------------
  pbl_host #(.MEM_WORDS(64)) i_pbl_host (.clk, .rst, .link(lnk), .address, .read, .write,
    .writedata, .readdata, .waitrequest, .request_fault_output);
  pbl_dev i_pbl_dev (.clk, .rst, .link(lnk), .store_we, .store_num, .store_data, .req_done,
    .req_code, .stat_is_bits, .stat_loc, .stat_span, .data_is_bits, .data_loc, .data_span);
  pbl_chk i_pbl_chk (.clk, .rst, .word_valid(lnk.word_valid), .word_ready(lnk.word_ready),
    .word_last(lnk.word_last), .word_data(lnk.word_data), .result_valid(lnk.result_valid),
    .result_code(lnk.result_code));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // parameter store monitor and cycle limit
  always @(posedge clk) begin
    cyc++;
    if (!rst && store_we === 1'b1) got_q.push_back({store_num, store_data});
    if (!rst && req_done === 1'b1) code_q.push_back(req_code);
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is low at an edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  // reference verdict of a block
  function automatic logic [15:0] model();
    int n;
    n = blk[11];
    if (blk[0] != 16'h0004) return ST_BAD_HDR;
    if (blk[6] != 16'he501) return ST_BAD_CMD;
    if (!(blk[2] inside {codes}) || !(blk[8] inside {codes})) return ST_BAD_TYPE;
    if (n < 1 || n > 16) return ST_BAD_CNT;
    if (blk[7] != 4 + 4 * n) return ST_BAD_SIZE;
    if (blk[10] + n - 1 > 255) return ST_BAD_RANGE;
    return ST_OK;
  endfunction
  task automatic run_req(input logic [9:0] bp);
    logic [31:0] r;
    logic [15:0] code;
    logic sb;
    logic db;
    int n;
    n = blk[11];
    code = model();
    sb = blk[2] inside {MT_DIN, MT_DOUT};
    db = blk[8] inside {MT_DIN, MT_DOUT};
    for (int k = 0; k < 44; k++) bus(1'b1, MEM_BASE + 10'(4 * (bp + k)), {16'h0, blk[k]}, r);
    bus(1'b1, MEM_BASE + 10'(4 * blk[3]), 32'h63, r);
    bus(1'b1, REG_BLKPTR, {22'h0, bp}, r);
    bus(1'b1, REG_CTRL, 32'h1, r);
    r = 32'h0;
    while (r[STAT_DONE_BIT] !== 1'b1) bus(1'b0, REG_STAT, 32'h0, r);
    check(r[STAT_FAULT_BIT], blk[7] == 16'h0);
    check(request_fault_output, blk[7] == 16'h0);
    if (blk[7] != 16'h0) begin
      bus(1'b0, REG_RESULT, 32'h0, r);
      check(r[15:0], code);
      bus(1'b0, MEM_BASE + 10'(4 * blk[3]), 32'h0, r);
      check(r[15:0], code);
      check(code_q[0], code);
    end
    check(code_q.size(), (blk[7] != 16'h0) ? 1 : 0);
    check(got_q.size(), (code == ST_OK) ? n : 0);
    if (code == ST_OK) begin
      check(stat_is_bits, sb);
      check(stat_loc, blk[3] + 16'h1);
      check(stat_span, sb ? 16'h10 : 16'h1);
      check(data_is_bits, db);
      check(data_loc, 16'(blk[9] + 16'h1));
      check(data_span, db ? 16'(32 + 32 * n) : 16'(2 + 2 * n));
      for (int k = 0; k < n; k++) begin
        check(got_q[k], {8'(blk[10] + k), blk[13 + 2 * k], blk[12 + 2 * k]});
      end
    end
    got_q.delete();
    code_q.delete();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    seed = 32'h64d5;
    codes = '{MT_REG, MT_AIN, MT_AOUT, MT_DIN, MT_DOUT};
    rst = 1'b1;
    address = 10'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 19; i++) begin
      n = (i == 0) ? 16 : (i == 1) ? 1 : (i == 14) ? 0 : 1 + {$random(seed)} % 16;
      foreach (blk[k]) blk[k] = 16'($random(seed));
      blk[0] = 16'h0004;
      blk[2] = codes[i % 5];
      blk[3] = 16'(48 + {$random(seed)} % 16);
      blk[6] = 16'he501;
      blk[7] = 16'(4 + 4 * n);
      blk[8] = codes[(i + 2) % 5];
      blk[10] = (i == 0) ? 16'h00f0 : 16'({$random(seed)} % (257 - n));
      blk[11] = 16'(n);
      case (i)
        10: blk[0] = 16'h0005;
        11: blk[6] = 16'he502;
        12: blk[2] = 16'h0009;
        13: blk[8] = 16'h0047;
        15: blk[7] = 16'(5 + 4 * n);
        16: blk[10] = 16'(257 - n);
        17: blk[10] = 16'(256 - n);
        18: blk[7] = 16'h0000;
        default: ;
      endcase
      run_req(10'({$random(seed)} % 4));
    end
    report_and_stop();
  end
endmodule
